// ---- line_peer.sv ----
`timescale 1ns/100ps
// ----
// serial peer listening on the transmit line
// ----
module line_peer (
    input wire logic clock_i,
    input wire logic line_i,
    input wire logic sck_i,
    input wire logic sdt_i,
    input int        bit_t_i,
    input int        nbits_i
);
    logic [9:0] got[$];
    logic [9:0] v;
    logic [7:0] sgot;
    // sync peer: takes the data pin at each rising clock, lsb first
    always @(posedge sck_i) sgot <= {sdt_i, sgot[7:1]};
    // start on the falling edge, lsb first, stop bit last
    always begin
        @(negedge line_i);
        repeat (bit_t_i / 2) @(posedge clock_i);
        v = '0;
        for (int i = 0; i <= nbits_i; i++) begin
            repeat (bit_t_i) @(posedge clock_i);
            v[i] = line_i;
        end
        got.push_back(v);
        // a break keeps the line low past the stop slot, so wait for idle
        wait (line_i);
    end
endmodule

// ---- serial_port_transmit_control_tb.sv ----
`timescale 1ns/100ps
module serial_port_transmit_control_tb;
    import serial_tx_pkg::*;
    // ----
    // signals
    // ----
    logic        clock_i, rst_i, ck_i, irq_o;
    logic [4:0]  s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, lfsr_s, rd;
    logic [3:0]  s_axi_wstrb_i;
    logic        s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
    logic        s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic        s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp, m, st;
    logic [7:0]  d;
    pin_drive_t  pins_o;
    int          err_total, n_checks, bit_t, nbits;
    serial_tx i_serial_tx (.clock_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
        .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
        .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ck_i, .pins_o, .irq_o);
    // released line floats high through the pull-up
    line_peer i_line_peer (.clock_i, .line_i(pins_o.ck_oe_n ? 1'b1 : pins_o.ck),
        .sck_i(pins_o.ck), .sdt_i(pins_o.dt), .bit_t_i(bit_t), .nbits_i(nbits));
    initial begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    // slave clock pin carries noise; async mode must ignore it
    always @(posedge clock_i) ck_i <= lfsr_s[3];
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one axi4-lite write or read, answer sampled at the falling edge before the rising edge that takes it
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
        logic ta, tw, tr;
        @(posedge clock_i);
        if (w) begin
            s_axi_awaddr_i <= a;
            s_axi_wdata_i <= {24'h000000, v};
            {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
        end else begin
            s_axi_araddr_i <= a;
            {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
        end
        do begin
            @(negedge clock_i);
            ta = w ? s_axi_awready_o : s_axi_arready_o;
            tw = s_axi_wready_o;
            tr = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            rd = s_axi_rdata_o;
            rsp = w ? s_axi_bresp_o : s_axi_rresp_o;
            @(posedge clock_i);
            if (ta) {s_axi_awvalid_i, s_axi_arvalid_i} <= 2'h0;
            if (tw) s_axi_wvalid_i <= 0;
        end while (!tr);
        {s_axi_bready_i, s_axi_rready_i} <= 2'h0;
    endtask
    // model: expected frame, status and flags from the control byte
    task automatic send(input logic [7:0] c, input logic wd);
        st = c[BREAK_REQ_BIT] ? 2'h3 : 2'h1;
        if (wd) begin
            lfsr_s = lfsr(lfsr_s);
            d = lfsr_s[7:0];
        end
        bus(1, ADDR_TX_CTRL, c);
        if (wd) bus(1, ADDR_TX_DATA, d);
        bus(0, ADDR_TX_CTRL, 0);
        chk("busy", c & 8'hFD, rd);
        for (int n = 0; n < 4000 && i_line_peer.got.size() == 0; n++) @(posedge clock_i);
        chk("frame", c[BREAK_REQ_BIT] ? 10'h000 : c[NINE_BIT] ? {1'b1, c[0], d} : {2'b01, d},
            i_line_peer.got.size() ? i_line_peer.got.pop_front() : 10'h3FF);
        repeat ((c[BREAK_REQ_BIT] ? 4 : 1) * bit_t) @(posedge clock_i);
        bus(0, ADDR_IRQ_STAT, 0);
        chk("status", st, rd);
        chk("irq", |(st & m), irq_o);
        bus(0, ADDR_TX_CTRL, 0);
        chk("ctrl", (c & 8'hF7) | 8'h02, rd);
        bus(1, ADDR_IRQ_STAT, 8'h03);
        repeat (2) @(posedge clock_i);
        chk("irq clear", 0, irq_o);
    endtask
    task automatic print_verdict;
        if (err_total == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock_i);
        err_total++;
        print_verdict();
    end
    // main sequence
    initial begin
        {rst_i, s_axi_wstrb_i, lfsr_s, m} = {1'b1, 4'hF, 32'h948B, 2'h0};
        bit_t = 64;
        nbits = 8;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 0;
        repeat (4) @(posedge clock_i);
        rst_i <= 0;
        bus(0, ADDR_TX_CTRL, 0);
        chk("reset", TX_CTRL_RESET, rd);
        bus(0, 5'h03, 0);
        chk("resp", RESP_SLVERR, rsp);
        bus(1, ADDR_RX_CTRL, 8'h80);
        chk("wresp", RESP_OKAY, rsp);
        bus(1, ADDR_TX_CTRL, 8'h00);
        d = 8'hA5;
        bus(1, ADDR_TX_DATA, d);
        repeat (300) @(posedge clock_i);
        chk("held", 0, i_line_peer.got.size());
        send(8'h20, 0);
        chk("oe", 2'h1, {pins_o.ck_oe_n, pins_o.dt_oe_n});
        m = 2'h3;
        bus(1, ADDR_IRQ_MASK, 8'h03);
        nbits = 9;
        send(8'h61, 1);
        send(8'h60, 1);
        nbits = 8;
        send(8'h28, 1);
        // divisor of one doubles the high-speed bit time
        bit_t = 32;
        bus(1, ADDR_DIV_LOW, 8'h01);
        send(8'h24, 1);
        // sync master: one data bit per generated clock, lsb first
        bus(1, ADDR_TX_CTRL, 8'hB0);
        lfsr_s = lfsr(lfsr_s);
        d = lfsr_s[7:0];
        bus(1, ADDR_TX_DATA, d);
        repeat (200) @(posedge clock_i);
        chk("sync data", d, i_line_peer.sgot);
        bus(0, ADDR_IRQ_STAT, 0);
        chk("sync status", 2'h1, rd);
        // a receive enable in sync mode holds the transmitter back
        bus(1, ADDR_RX_CTRL, 8'hA0);
        bus(1, ADDR_TX_DATA, 8'h3C);
        repeat (100) @(posedge clock_i);
        bus(0, ADDR_TX_CTRL, 0);
        chk("rx wins", 8'hB2, rd);
        print_verdict();
    end
endmodule

// ---- serial_tx.sv ----
`timescale 1ns/100ps
module serial_tx
    import serial_tx_pkg::*;
(
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    // axi4-lite write channels
    input  wire logic [4:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read channels
    input  wire logic [4:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // shared pins
    input  wire logic        ck_i,
    output pin_drive_t       pins_o,
    // interrupt
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [7:0]   tx_ctrl_reg;
    logic [7:0]   rx_ctrl_reg;
    logic [7:0]   rate_ctrl_reg;
    logic [7:0]   div_low_reg;
    logic [7:0]   div_high_reg;
    logic [8:0]   hold_reg;
    logic         hold_full_reg;
    logic [1:0]   irq_stat_reg;
    logic [1:0]   irq_mask_reg;
    logic [4:0]   awaddr_reg;
    logic         aw_have_reg;
    logic [31:0]  wdata_reg;
    logic         w_have_reg;
    logic [15:0]  rate_cnt_reg;
    logic [5:0]   presc_reg;
    shift_state_t state_reg;
    logic [8:0]   shifter_reg;
    logic [3:0]   bit_cnt_reg;
    logic         is_break_reg;
    logic         ck_meta_reg;
    logic         ck_sync_reg;
    logic         ck_prev_reg;
    pin_drive_t   pins_next;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    wire port_on    = rx_ctrl_reg[PORT_ON_BIT];
    wire sync_mode  = tx_ctrl_reg[SYNC_MODE_BIT];
    wire master     = tx_ctrl_reg[CLK_SRC_BIT];
    wire nine_bits  = tx_ctrl_reg[NINE_BIT];
    wire clk_pol    = rate_ctrl_reg[CLK_POL_BIT];
    wire wide_div   = rate_ctrl_reg[WIDE_DIV_BIT];
    wire rx_on      = rx_ctrl_reg[SINGLE_RX_BIT] | rx_ctrl_reg[CONT_RX_BIT];
    // receive enables win over transmit enable in sync mode
    wire tx_allowed = tx_ctrl_reg[TX_ON_BIT] & ~(sync_mode & rx_on);
    wire shifter_empty = (state_reg == ST_IDLE);

    // ------------------------------------------------------------------
    // axi decode
    // ------------------------------------------------------------------
    wire       wr_go     = aw_have_reg & w_have_reg & ~s_axi_bvalid_o;
    wire [7:0] wr_byte   = wdata_reg[7:0];
    wire       wr_ctrl   = wr_go & (awaddr_reg == ADDR_TX_CTRL);
    wire       wr_rxc    = wr_go & (awaddr_reg == ADDR_RX_CTRL);
    wire       wr_ratec  = wr_go & (awaddr_reg == ADDR_RATE_CTRL);
    wire       wr_divlo  = wr_go & (awaddr_reg == ADDR_DIV_LOW);
    wire       wr_divhi  = wr_go & (awaddr_reg == ADDR_DIV_HIGH);
    wire       wr_data   = wr_go & (awaddr_reg == ADDR_TX_DATA);
    wire       wr_istat  = wr_go & (awaddr_reg == ADDR_IRQ_STAT);
    wire       wr_imask  = wr_go & (awaddr_reg == ADDR_IRQ_MASK);
    wire       wr_mapped = wr_ctrl | wr_rxc | wr_ratec | wr_divlo | wr_divhi
                         | wr_data | wr_istat | wr_imask;
    wire       rd_go     = s_axi_arvalid_i & s_axi_arready_o;
    wire [7:0] ctrl_view = {tx_ctrl_reg[7:2], shifter_empty, tx_ctrl_reg[0]};
    wire       rd_mapped = (s_axi_araddr_i[1:0] == 2'h0) & (s_axi_araddr_i <= ADDR_IRQ_MASK);
    wire [7:0] rd_byte   =
        (s_axi_araddr_i == ADDR_TX_CTRL)   ? ctrl_view :
        (s_axi_araddr_i == ADDR_RX_CTRL)   ? rx_ctrl_reg :
        (s_axi_araddr_i == ADDR_RATE_CTRL) ? rate_ctrl_reg :
        (s_axi_araddr_i == ADDR_DIV_LOW)   ? div_low_reg :
        (s_axi_araddr_i == ADDR_DIV_HIGH)  ? div_high_reg :
        (s_axi_araddr_i == ADDR_IRQ_STAT)  ? {6'h00, irq_stat_reg} :
        (s_axi_araddr_i == ADDR_IRQ_MASK)  ? {6'h00, irq_mask_reg} : 8'h00;

    // ------------------------------------------------------------------
    // rate divider and bit timing
    // ------------------------------------------------------------------
    wire [15:0] reload     = wide_div ? {div_high_reg, div_low_reg}
                                      : {8'h00, div_low_reg};
    wire        rate_tick  = (rate_cnt_reg == 16'h0000);
    // prescale per mode: async low/high speed and divider width, sync fixed
    wire [5:0]  presc_top  = sync_mode ? PRESC_FAST :
                             (wide_div & tx_ctrl_reg[HIGH_SPEED_BIT]) ? PRESC_FAST :
                             (wide_div | tx_ctrl_reg[HIGH_SPEED_BIT]) ? PRESC_MID :
                             PRESC_SLOW;
    wire        bit_tick   = rate_tick & (presc_reg == presc_top);
    wire        load       = port_on & tx_allowed & hold_full_reg & shifter_empty;
    // a divisor write or a new frame restarts the timer, so no stale count
    wire        tmr_clear  = wr_divlo | wr_divhi | load;
    wire        ck_trail   = (ck_prev_reg != clk_pol) & (ck_sync_reg == clk_pol);
    wire        step       = (sync_mode & ~master) ? ck_trail : bit_tick;
    wire        send_break = ~sync_mode & tx_ctrl_reg[BREAK_REQ_BIT];
    wire [3:0]  last_data  = nine_bits ? LAST_BIT_9 : LAST_BIT_8;
    wire        data_last  = (bit_cnt_reg == last_data);
    wire        frame_done = step & ((state_reg == ST_STOP)
                           | (state_reg == ST_DATA & sync_mode & data_last));
    wire        break_done = frame_done & is_break_reg;

    // timer: counts down from the reload value, restarted on demand
    always_ff @(posedge clock_i) begin
        if (rst_i || !port_on || tmr_clear) begin
            rate_cnt_reg <= rst_i ? 16'h0000 : reload;
            presc_reg    <= 6'h00;
        end else if (rate_tick) begin
            rate_cnt_reg <= reload;
            presc_reg    <= (presc_reg == presc_top) ? 6'h00 : presc_reg + 6'h01;
        end else begin
            rate_cnt_reg <= rate_cnt_reg - 16'h0001;
        end
    end

    // slave clock pin: two stages before any logic looks at it
    always_ff @(posedge clock_i) begin
        ck_meta_reg <= ck_i;
        ck_sync_reg <= ck_meta_reg;
        ck_prev_reg <= ck_sync_reg;
    end

    // ------------------------------------------------------------------
    // transmit shifter
    // ------------------------------------------------------------------
    // frame sequencer; sync frames carry data only, async adds start/stop
    always_ff @(posedge clock_i) begin
        if (rst_i || !port_on) begin
            state_reg    <= ST_IDLE;
            shifter_reg  <= 9'h000;
            bit_cnt_reg  <= 4'h0;
            is_break_reg <= 1'b0;
        end else if (load) begin
            shifter_reg  <= hold_reg;
            bit_cnt_reg  <= 4'h0;
            is_break_reg <= send_break;
            state_reg    <= sync_mode ? ST_DATA : ST_START;
        end else if (step) begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_IDLE;
                end
                ST_START: begin
                    state_reg <= is_break_reg ? ST_BREAK : ST_DATA;
                end
                ST_DATA: begin
                    shifter_reg <= {1'b0, shifter_reg[8:1]};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (data_last) begin
                        state_reg <= sync_mode ? ST_IDLE : ST_STOP;
                    end
                end
                ST_BREAK: begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (bit_cnt_reg == LAST_BREAK - 4'h1) begin
                        state_reg <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // pin drive: async uses the clock pin as serial out, sync splits them
    always_comb begin
        pins_next = '{ck: 1'b1, ck_oe_n: 1'b1, dt: 1'b1, dt_oe_n: 1'b1};
        if (port_on && !sync_mode) begin
            pins_next.ck_oe_n = 1'b0;
            pins_next.ck = (state_reg == ST_START) ? 1'b0 :
                           (state_reg == ST_BREAK) ? 1'b0 :
                           (state_reg == ST_DATA)  ? shifter_reg[0] : 1'b1;
        end else if (port_on) begin
            // slave leaves the clock pin an input; data only while sending
            pins_next.ck_oe_n = ~master;
            pins_next.ck = clk_pol ^ ((state_reg == ST_DATA) & (presc_reg >= PRESC_HALF));
            pins_next.dt_oe_n = (state_reg != ST_DATA);
            pins_next.dt = shifter_reg[0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pins_o <= '{ck: 1'b1, ck_oe_n: 1'b1, dt: 1'b1, dt_oe_n: 1'b1};
        end else begin
            pins_o <= pins_next;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // control writes; hardware clears the break request once it has gone
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_ctrl_reg   <= TX_CTRL_RESET;
            rx_ctrl_reg   <= REG8_RESET;
            rate_ctrl_reg <= REG8_RESET;
            div_low_reg   <= REG8_RESET;
            div_high_reg  <= REG8_RESET;
            irq_mask_reg  <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                tx_ctrl_reg <= wr_byte;
            end else if (break_done) begin
                tx_ctrl_reg[BREAK_REQ_BIT] <= 1'b0;
            end
            if (wr_rxc)   rx_ctrl_reg   <= wr_byte & 8'hB0;
            if (wr_ratec) rate_ctrl_reg <= wr_byte & 8'h18;
            if (wr_divlo) div_low_reg   <= wr_byte;
            if (wr_divhi) div_high_reg  <= wr_byte;
            if (wr_imask) irq_mask_reg  <= wr_byte[1:0];
        end
    end

    // one holding word; the ninth bit is taken from control at write time
    always_ff @(posedge clock_i) begin
        if (rst_i || !port_on) begin
            hold_reg      <= 9'h000;
            hold_full_reg <= 1'b0;
        end else if (wr_data) begin
            hold_reg      <= {tx_ctrl_reg[NINTH_DATA_BIT] & nine_bits, wr_byte};
            hold_full_reg <= 1'b1;
        end else if (load) begin
            hold_full_reg <= 1'b0;
        end
    end

    // sticky events; a set in the clearing cycle survives
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_stat_reg <= 2'h0;
            irq_o        <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~({2{wr_istat}} & wr_byte[1:0]))
                          | {break_done, frame_done};
            irq_o        <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    // address and data may arrive in either order; response after both
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            aw_have_reg     <= 1'b0;
            w_have_reg      <= 1'b0;
            awaddr_reg      <= 5'h00;
            wdata_reg       <= 32'h0000_0000;
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o  <= 1'b0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= RESP_OKAY;
        end else begin
            s_axi_awready_o <= ~aw_have_reg & ~s_axi_awready_o;
            s_axi_wready_o  <= ~w_have_reg & ~s_axi_wready_o;
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_have_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_have_reg <= 1'b1;
                // only lane 0 holds data; a write without it stores zero
                wdata_reg  <= s_axi_wstrb_i[0] ? s_axi_wdata_i : 32'h0000_0000;
            end
            if (wr_go) begin
                aw_have_reg    <= 1'b0;
                w_have_reg     <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // reads answer one cycle after the address is taken
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= RESP_OKAY;
        end else begin
            s_axi_arready_o <= ~s_axi_arready_o & ~s_axi_rvalid_o & s_axi_arvalid_i;
            if (rd_go) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o  <= {24'h00_0000, rd_byte};
                s_axi_rresp_o  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence seq_load;
        load;
    endsequence

    sequence seq_break_end;
        break_done && !wr_ctrl;
    endsequence

    AST_PORT_OFF: assert property (@(posedge clock_i) disable iff (rst_i)
        !port_on |=> pins_o.ck_oe_n && pins_o.dt_oe_n && state_reg == ST_IDLE)
        else $error("port off did not release pins");

    AST_BREAK_CLEAR: assert property (@(posedge clock_i) disable iff (rst_i)
        seq_break_end |=> !tx_ctrl_reg[BREAK_REQ_BIT])
        else $error("break request not cleared after break");

    AST_BREAK_LEN: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == ST_BREAK) && step && port_on |-> bit_cnt_reg <= LAST_BREAK - 4'h1)
        else $error("break longer than twelve bit times");

    AST_IDLE_HIGH: assert property (@(posedge clock_i) disable iff (rst_i)
        (port_on && !sync_mode && state_reg == ST_IDLE)[*2] |-> pins_o.ck)
        else $error("async line not high while idle");

    AST_START_LOW: assert property (@(posedge clock_i) disable iff (rst_i)
        (port_on && !sync_mode && state_reg == ST_START)[*2] |-> !pins_o.ck)
        else $error("start bit not low");

    AST_RX_WINS: assert property (@(posedge clock_i) disable iff (rst_i)
        sync_mode && rx_on && state_reg == ST_IDLE && !wr_ctrl && !wr_rxc
        |=> state_reg == ST_IDLE)
        else $error("sync transmit started while receive enabled");

    AST_FRAME_BITS: assert property (@(posedge clock_i) disable iff (rst_i)
        (state_reg == ST_DATA) && step && port_on && !load |-> bit_cnt_reg <= last_data)
        else $error("data bit count exceeds frame width");

    AST_EMPTY_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
        seq_load |=> !ctrl_view[EMPTY_BIT] ##0 (state_reg != ST_IDLE))
        else $error("empty flag still set after shifter load");

    AST_RATE_RESTART: assert property (@(posedge clock_i) disable iff (rst_i)
        (wr_divlo || wr_divhi) && port_on |=> presc_reg == 6'h00)
        else $error("divisor write did not restart timer");

    AST_SYNC_DT_DRIVE: assert property (@(posedge clock_i) disable iff (rst_i)
        (port_on && sync_mode && state_reg == ST_DATA)[*2] |-> !pins_o.dt_oe_n)
        else $error("data pin not driven during sync transmit");

endmodule

// ---- serial_tx_pkg.sv ----
package serial_tx_pkg;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_TX_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_RX_CTRL   = 5'h04;
    localparam logic [4:0] ADDR_RATE_CTRL = 5'h08;
    localparam logic [4:0] ADDR_DIV_LOW   = 5'h0C;
    localparam logic [4:0] ADDR_DIV_HIGH  = 5'h10;
    localparam logic [4:0] ADDR_TX_DATA   = 5'h14;
    localparam logic [4:0] ADDR_IRQ_STAT  = 5'h18;
    localparam logic [4:0] ADDR_IRQ_MASK  = 5'h1C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CLK_SRC_BIT    = 7;  // transmit control fields
    localparam int NINE_BIT       = 6;
    localparam int TX_ON_BIT      = 5;
    localparam int SYNC_MODE_BIT  = 4;
    localparam int BREAK_REQ_BIT  = 3;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int EMPTY_BIT      = 1;
    localparam int NINTH_DATA_BIT = 0;
    localparam int PORT_ON_BIT    = 7;  // receive control fields
    localparam int SINGLE_RX_BIT  = 5;
    localparam int CONT_RX_BIT    = 4;
    localparam int CLK_POL_BIT    = 4;  // rate control fields
    localparam int WIDE_DIV_BIT   = 3;
    localparam int IRQ_DONE_BIT   = 0;  // interrupt fields
    localparam int IRQ_BREAK_BIT  = 1;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] TX_CTRL_RESET = 8'h02;
    localparam logic [7:0] REG8_RESET    = 8'h00;
    localparam logic [5:0] PRESC_SLOW    = 6'h3F;  // 64 timer periods per bit
    localparam logic [5:0] PRESC_MID     = 6'h0F;  // 16 timer periods per bit
    localparam logic [5:0] PRESC_FAST    = 6'h03;  // 4 timer periods per bit
    localparam logic [5:0] PRESC_HALF    = 6'h02;  // sync clock active half
    localparam logic [3:0] LAST_BIT_8    = 4'h7;
    localparam logic [3:0] LAST_BIT_9    = 4'h8;
    localparam logic [3:0] LAST_BREAK    = 4'hB;   // 12 low bit times
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

    // shifter states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_DATA  = 3'b010,
        ST_STOP  = 3'b011,
        ST_BREAK = 3'b100
    } shift_state_t;

    // drive of the two shared pins; enables are low while driving
    typedef struct packed {
        logic ck;
        logic ck_oe_n;
        logic dt;
        logic dt_oe_n;
    } pin_drive_t;

endpackage
